/* File: rtl/drive_safety_map.vh */
// Constants for the drive safety outputs block
`ifndef DRIVE_SAFETY_MAP_VH
`define DRIVE_SAFETY_MAP_VH
`define CLK_PERIOD_NS      32'd50
`define AXIS_COUNT         6
`define DAC_WIDTH          16
`define DAC_SER_BITS       5'd16
`define CAN_CMD_ID_BASE    11'h010
`define CAN_FB_ID_BASE     11'h020
`define CAN_ID_WIDTH       11
`define CAN_DLC            4'h4
`define CAN_BIT_RATE_BPS   32'd1000000
`define CAN_BIT_CYCLES     (20000000 / 1000000)
`define WDT_DEFAULT_NS     32'd3000000
`endif

/* File: rtl/dac_serial_tx.v */
// Serial shifter feeding one axis converter
`timescale 1ns/1ps
`include "drive_safety_map.vh"
module dac_serial_tx #(
	parameter W = `DAC_WIDTH
) (
	// Clock and reset
	input  wire         clk_i,
	input  wire         rst_n_i,
	// Word to send
	input  wire         start_i,
	input  wire [W-1:0] word_i,
	input  wire         invert_i,
	// Serial line
	output reg          ser_o,
	output reg          busy_o
);
	reg [W-1:0] shift_r;
	reg [4:0]   cnt_r;
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shift_r <= {W{1'b0}};
			cnt_r   <= 5'h00;
			busy_o  <= 1'b0;
			ser_o   <= 1'b1;
		end else if (!busy_o) begin
			// Idle level is high; isolated converters see it inverted
			ser_o <= ~invert_i;
			if (start_i) begin
				shift_r <= word_i;
				cnt_r   <= `DAC_SER_BITS;
				busy_o  <= 1'b1;
				ser_o   <= invert_i; // start bit
			end
		end else begin
			ser_o   <= shift_r[W-1] ^ ~invert_i;
			shift_r <= {shift_r[W-2:0], 1'b0};
			cnt_r   <= cnt_r - 5'h01;
			if (cnt_r == 5'h00) begin
				busy_o <= 1'b0;
				ser_o  <= ~invert_i;
			end
		end
	end
endmodule

/* File: rtl/axis_drive_safety_outputs.v */
// Drive enable, watchdog, axis converter feeds and CAN position frames
`timescale 1ns/1ps
`include "drive_safety_map.vh"
module axis_drive_safety_outputs #(
	parameter N  = `AXIS_COUNT,
	parameter W  = `DAC_WIDTH,
	parameter BC = `CAN_BIT_CYCLES
) (
	// Clock and reset
	input  wire           clk_i,
	input  wire           rst_n_i,
	// Host enable, watchdog control and status
	input  wire           power_enable_i,
	input  wire           wdt_enable_i,
	input  wire [31:0]    timeout_interval_ns_i,
	input  wire           wdt_service_i,
	output reg            wdt_expired_o,
	output reg            power_fault_o,
	// Shared connector pins
	input  wire           power_fault_pin_i,
	output reg            drive_enable_o,
	// Converter channels
	input  wire [N-1:0]   dac_enable_i,
	input  wire [N*W-1:0] dac_value_i,
	input  wire [N*W-1:0] dac_offset_i,
	input  wire [N*W-1:0] dac_high_i,
	input  wire [N*W-1:0] dac_low_i,
	input  wire [N-1:0]   dac_invert_i,
	input  wire           dac_update_i,
	output wire [N-1:0]   dac_ser_o,
	// CAN side
	input  wire [N-1:0]   can_enable_i,
	input  wire [N*32-1:0] can_position_i,
	input  wire           can_send_i,
	input  wire           can_rx_valid_i,
	input  wire [10:0]    can_rx_id_i,
	input  wire [31:0]    can_rx_data_i,
	output reg  [N*32-1:0] returned_position_o,
	output reg  [N-1:0]   returned_valid_o,
	output reg            can_tx_o,
	output reg            can_busy_o
);
	// Fault pin synchroniser
	reg        fault_s1_r;
	reg        fault_s2_r;
	reg [31:0] wdt_cnt_r;
	reg [31:0] wdt_limit_r;
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fault_s1_r <= 1'b0;
			fault_s2_r <= 1'b0;
		end else begin
			fault_s1_r <= power_fault_pin_i;
			fault_s2_r <= fault_s1_r;
		end
	end

	// Watchdog: limit in clock cycles derived from the nanosecond timeout
	wire        wdt_hit;
	reg  [31:0] wdt_cnt_nxt;
	reg         wdt_expired_nxt;
	assign wdt_hit = (wdt_cnt_r >= wdt_limit_r);
	// Clear wins over expiry so a service always restarts a full interval
	always @* begin
		wdt_cnt_nxt     = wdt_cnt_r;
		wdt_expired_nxt = wdt_expired_o;
		if (!wdt_enable_i || wdt_service_i) begin
			wdt_cnt_nxt     = 32'h00000000;
			wdt_expired_nxt = 1'b0;
		end else if (wdt_hit) begin
			wdt_expired_nxt = 1'b1;
		end else begin
			wdt_cnt_nxt = wdt_cnt_r + 32'h00000001;
		end
	end
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wdt_limit_r   <= 32'h00000001;
			wdt_cnt_r     <= 32'h00000000;
			wdt_expired_o <= 1'b0;
		end else begin
			wdt_limit_r   <= timeout_interval_ns_i / `CLK_PERIOD_NS;
			wdt_cnt_r     <= wdt_cnt_nxt;
			wdt_expired_o <= wdt_expired_nxt;
		end
	end

	// Expired flag gates enable directly, no software in path
	wire drive_enable_nxt;
	assign drive_enable_nxt = power_enable_i & ~fault_s2_r &
		~(wdt_enable_i & (wdt_expired_o | wdt_hit));
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			drive_enable_o <= 1'b0;
			power_fault_o  <= 1'b0;
		end else begin
			power_fault_o  <= fault_s2_r;
			drive_enable_o <= drive_enable_nxt;
		end
	end

	// Converter channels
	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : ch
			wire signed [W-1:0] val = dac_value_i[g*W +: W];
			wire signed [W-1:0] off = dac_offset_i[g*W +: W];
			wire signed [W-1:0] hi  = dac_high_i[g*W +: W];
			wire signed [W-1:0] lo  = dac_low_i[g*W +: W];
			wire signed [W:0]   sum = {val[W-1], val} + {off[W-1], off};
			// Limits widened as signed so the compare stays signed
			wire signed [W:0]   hi_x = {hi[W-1], hi};
			wire signed [W:0]   lo_x = {lo[W-1], lo};
			reg  signed [W-1:0] word_r;
			reg  signed [W-1:0] word_nxt;
			always @* begin
				word_nxt = sum[W-1:0];
				if (!dac_enable_i[g])
					word_nxt = {W{1'b0}};
				else if (sum > hi_x)
					word_nxt = hi;
				else if (sum < lo_x)
					word_nxt = lo;
			end
			always @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i)
					word_r <= {W{1'b0}};
				else
					word_r <= word_nxt;
			end
			dac_serial_tx #(.W(W)) u_tx (
				.clk_i    (clk_i),
				.rst_n_i  (rst_n_i),
				.start_i  (dac_update_i),
				.word_i   (word_r),
				.invert_i (dac_invert_i[g]),
				.ser_o    (dac_ser_o[g]),
				.busy_o   ()
			);
		end
	endgenerate

	// Feedback capture for identifiers 0x20..0x25
	integer        k;
	reg [N*32-1:0] ret_pos_nxt;
	reg [N-1:0]    ret_valid_nxt;
	always @* begin
		ret_pos_nxt   = returned_position_o;
		ret_valid_nxt = {N{1'b0}};
		for (k = 0; k < N; k = k + 1) begin
			if (can_rx_valid_i &&
			    can_rx_id_i == `CAN_FB_ID_BASE + k[10:0]) begin
				ret_pos_nxt[k*32 +: 32] = can_rx_data_i;
				ret_valid_nxt[k]        = 1'b1;
			end
		end
	end
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			returned_position_o <= {N*32{1'b0}};
			returned_valid_o    <= {N{1'b0}};
		end else begin
			returned_position_o <= ret_pos_nxt;
			returned_valid_o    <= ret_valid_nxt;
		end
	end

	// CAN command transmitter: one frame per enabled axis per send request
	localparam S_IDLE = 3'b001;
	localparam S_LOAD = 3'b010;
	localparam S_SEND = 3'b100;
	// SOF, identifier, three control zeros, DLC, data, recessive tail
	localparam FL = 56;
	reg [2:0]    state_r;
	reg [2:0]    axis_r;
	reg [FL-1:0] frame_r;
	reg [6:0]    bits_r;
	reg [7:0]    bcnt_r;
	reg [2:0]    state_nxt;
	reg [2:0]    axis_nxt;
	reg [FL-1:0] frame_nxt;
	reg [6:0]    bits_nxt;
	reg [7:0]    bcnt_nxt;
	reg          tx_nxt;
	reg          busy_nxt;
	reg [31:0]   pos;
	reg [10:0]   id;
	always @* begin
		pos       = can_position_i[axis_r*32 +: 32];
		id        = `CAN_CMD_ID_BASE + {8'h00, axis_r};
		state_nxt = state_r;
		axis_nxt  = axis_r;
		frame_nxt = frame_r;
		bits_nxt  = bits_r;
		bcnt_nxt  = bcnt_r;
		tx_nxt    = can_tx_o;
		busy_nxt  = can_busy_o;
		case (state_r)
		S_IDLE: begin
			tx_nxt   = 1'b1;
			axis_nxt = 3'h0;
			if (can_send_i) begin
				state_nxt = S_LOAD;
				busy_nxt  = 1'b1;
			end
		end
		S_LOAD: begin
			if (axis_r == N[2:0]) begin
				state_nxt = S_IDLE;
				busy_nxt  = 1'b0;
			end else if (can_enable_i[axis_r]) begin
				// Data bytes go out least significant first
				frame_nxt = {1'b0, id, 3'b000, `CAN_DLC,
					pos[7:0], pos[15:8], pos[23:16],
					pos[31:24], 5'h1F};
				bits_nxt  = FL[6:0];
				bcnt_nxt  = 8'h00;
				state_nxt = S_SEND;
			end else begin
				axis_nxt = axis_r + 3'h1;
			end
		end
		S_SEND: begin
			if (bcnt_r == 8'h00) begin
				bcnt_nxt = BC[7:0] - 8'h01;
				if (bits_r == 7'h00) begin
					tx_nxt    = 1'b1;
					axis_nxt  = axis_r + 3'h1;
					state_nxt = S_LOAD;
				end else begin
					tx_nxt    = frame_r[FL-1];
					frame_nxt = {frame_r[FL-2:0], 1'b1};
					bits_nxt  = bits_r - 7'h01;
				end
			end else begin
				bcnt_nxt = bcnt_r - 8'h01;
			end
		end
		default: state_nxt = S_IDLE;
		endcase
	end
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r    <= S_IDLE;
			axis_r     <= 3'h0;
			frame_r    <= {FL{1'b1}};
			bits_r     <= 7'h00;
			bcnt_r     <= 8'h00;
			can_tx_o   <= 1'b1;
			can_busy_o <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			axis_r     <= axis_nxt;
			frame_r    <= frame_nxt;
			bits_r     <= bits_nxt;
			bcnt_r     <= bcnt_nxt;
			can_tx_o   <= tx_nxt;
			can_busy_o <= busy_nxt;
		end
	end
endmodule

/* File: tb/drive_safety_props.sv */
// Port checker for the drive safety outputs block
`timescale 1ns/1ps
module drive_safety_props #(
	parameter N = 6
) (
	input wire         clk_i,
	input wire         rst_n_i,
	input wire         power_enable_i,
	input wire         wdt_enable_i,
	input wire         wdt_service_i,
	input wire         wdt_expired_o,
	input wire         drive_enable_o,
	input wire [N-1:0] can_enable_i,
	input wire         can_send_i,
	input wire         can_busy_o,
	input wire         can_tx_o,
	input wire         can_rx_valid_i,
	input wire [N-1:0] returned_valid_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	chk_en_expired: assert property (!(drive_enable_o && wdt_expired_o))
		else $error("enable while expired");
	chk_en_host: assert property (drive_enable_o |->
		power_enable_i || $past(power_enable_i))
		else $error("enable without host");
	chk_svc_clear: assert property (wdt_service_i |=> !wdt_expired_o)
		else $error("service kept flag");
	chk_off_clear: assert property (!wdt_enable_i |=> !wdt_expired_o)
		else $error("flag while off");
	chk_flag_hold: assert property (wdt_expired_o && wdt_enable_i &&
		!wdt_service_i |=> wdt_expired_o)
		else $error("flag dropped");
	chk_tx_idle: assert property (!can_busy_o |-> can_tx_o)
		else $error("tx dominant idle");
	chk_send_busy: assert property (can_send_i && !can_busy_o &&
		(|can_enable_i) |-> ##[1:2] can_busy_o)
		else $error("send ignored");
	chk_fb_cause: assert property ((|returned_valid_o) |->
		$past(can_rx_valid_i))
		else $error("feedback without frame");
endmodule
bind axis_drive_safety_outputs drive_safety_props #(.N(N)) props_inst (.*);

/* File: tb/servo_model.sv */
// Servo amplifier model: decodes command frames, returns feedback
`timescale 1ns/1ps
module servo_model (
	input  wire        clk_i,
	input  wire        tx_i,
	output reg         vld_o,
	output reg  [10:0] id_o,
	output reg  [31:0] dat_o
);
	reg   [50:0] f;
	logic [50:0] fr[$];
	integer      k;
	initial begin
		{vld_o, id_o, dat_o} = 0;
		forever begin
			@(negedge tx_i);
			repeat (10) @(posedge clk_i);
			for (k = 0; k < 51; k = k + 1) begin
				f = {f[49:0], tx_i};
				repeat (20) @(posedge clk_i);
			end
			repeat (80) @(posedge clk_i);
			fr.push_back(f);
			id_o <= f[49:39] + 11'h010;
			dat_o <= ~{f[7:0], f[15:8], f[23:16], f[31:24]};
			vld_o <= 1'b1;
			@(posedge clk_i);
			vld_o <= 1'b0;
			{id_o, dat_o} <= ~{id_o, dat_o};
		end
	end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the drive safety outputs block
`timescale 1ns/1ps
module tb_top;
	reg           clk_i, rst_n_i, power_enable_i, wdt_enable_i, wdt_service_i;
	reg           power_fault_pin_i, dac_update_i, can_send_i;
	reg  [31:0]   timeout_interval_ns_i;
	reg  [5:0]    dac_enable_i, dac_invert_i, can_enable_i;
	reg  [95:0]   dac_value_i, dac_offset_i, dac_high_i, dac_low_i;
	reg  [191:0]  can_position_i;
	wire          wdt_expired_o, power_fault_o, drive_enable_o, can_tx_o;
	wire          can_busy_o, can_rx_valid_i;
	wire [10:0]   can_rx_id_i;
	wire [31:0]   can_rx_data_i;
	wire [5:0]    dac_ser_o, returned_valid_o;
	wire [191:0]  returned_position_o;
	integer       errors, check_count, k, n, r, b, v, hi, L;
	reg  [15:0]   g[0:5];
	logic [50:0]  q[$];
	axis_drive_safety_outputs axis_drive_safety_outputs_inst (.*);
	servo_model servo_model_inst (.clk_i, .tx_i(can_tx_o),
		.vld_o(can_rx_valid_i), .id_o(can_rx_id_i), .dat_o(can_rx_data_i));
	task step(input integer c);
		repeat (c) @(negedge clk_i);
	endtask
	task chk(input [63:0] got, input [63:0] exp);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("Error at %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task svc;
		begin
			wdt_service_i = 1;
			step(1);
			wdt_service_i = 0;
		end
	endtask
	task results;
		begin
			$display("checks %0d errors %0d", check_count, errors);
			if (errors == 0 && check_count > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	initial begin
		clk_i = 0;
		forever #25 clk_i = ~clk_i;
	end
	initial begin
		repeat (40000) @(posedge clk_i);
		errors = errors + 1;
		results;
	end
	initial begin
		{rst_n_i, power_enable_i, wdt_enable_i, wdt_service_i} = 0;
		{power_fault_pin_i, dac_update_i, can_send_i} = 0;
		{timeout_interval_ns_i, dac_enable_i, dac_invert_i, can_enable_i} = 0;
		{dac_value_i, dac_offset_i, dac_high_i, dac_low_i} = 0;
		can_position_i = 0;
		errors = 0;
		check_count = 0;
		k = $urandom(69219);
		step(8);
		rst_n_i = 1;
		power_enable_i = 1;
		step(5);
		chk(drive_enable_o, 1);
		power_fault_pin_i = 1;
		step(5);
		chk({power_fault_o, drive_enable_o}, 2'b10);
		power_fault_pin_i = 0;
		wdt_enable_i = 1;
		for (r = 1; r < 3; r = r + 1) begin
			timeout_interval_ns_i = 500 * r;
			L = 10 * r;
			svc;
			for (k = 0; k < 99 && wdt_expired_o !== 1; k = k + 1)
				step(1);
			chk(k >= L && k <= L + 2, 1);
			chk(drive_enable_o, 0);
			svc;
			step(1);
			chk(wdt_expired_o, 0);
			for (k = 0; k < 9; k = k + 1) begin
				step(L / 3 - 1);
				svc;
			end
			chk({wdt_expired_o, drive_enable_o}, 2'b01);
		end
		wdt_enable_i = 0;
		for (r = 0; r < 4; r = r + 1) begin
			for (n = 0; n < 6; n = n + 1) begin
				dac_value_i[n*16+:16] = $urandom % 32768 - 16384;
				dac_offset_i[n*16+:16] = $urandom % 2048 - 1024;
				hi = $urandom % 16384;
				dac_high_i[n*16+:16] = hi;
				dac_low_i[n*16+:16] = -hi;
			end
			dac_enable_i = $urandom;
			dac_invert_i = $urandom;
			step(3);
			chk(dac_ser_o, {~dac_invert_i});
			dac_update_i = 1;
			step(1);
			dac_update_i = 0;
			for (k = 0; k < 9 && dac_ser_o[0] !== dac_invert_i[0]; k = k + 1)
				step(1);
			for (b = 15; b >= 0; b = b - 1) begin
				step(1);
				for (n = 0; n < 6; n = n + 1)
					g[n][b] = dac_ser_o[n] ^ ~dac_invert_i[n];
			end
			for (n = 0; n < 6; n = n + 1) begin
				v = $signed(dac_value_i[n*16+:16])
					+ $signed(dac_offset_i[n*16+:16]);
				hi = $signed(dac_high_i[n*16+:16]);
				if (v > hi) v = hi;
				if (v < -hi) v = -hi;
				if (!dac_enable_i[n]) v = 0;
				chk(g[n], v[15:0]);
			end
		end
		for (r = 0; r < 3; r = r + 1) begin
			can_enable_i = r ? $urandom : 0;
			for (n = 0; n < 6; n = n + 1) begin
				can_position_i[n*32+:32] = $urandom;
				v = can_position_i[n*32+:32];
				if (can_enable_i[n])
					q.push_back({1'b0, 11'h010 + n[10:0], 7'h04, v[7:0],
						v[15:8], v[23:16], v[31:24]});
			end
			can_send_i = 1;
			step(1);
			can_send_i = 0;
			for (k = 0; k < 9000 && can_busy_o !== 0; k = k + 1)
				step(1);
			step(100);
			chk(servo_model_inst.fr.size(), q.size());
			while (q.size() && servo_model_inst.fr.size())
				chk(servo_model_inst.fr.pop_front(), q.pop_front());
			q.delete();
			servo_model_inst.fr.delete();
			for (n = 0; n < 6; n = n + 1)
				if (can_enable_i[n])
					chk(returned_position_o[n*32+:32],
						{~can_position_i[n*32+:32]});
		end
		results;
	end
endmodule
